/* logic/hpfc_top.sv */
// host port pause control register and its output steering
// assumes an apb master on SYS_CLK_I, straps and loader on pins or other clocks
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

module hpfc_top (
  // clock and reset
  input  wire logic                                SYS_CLK_I,
  input  wire logic                                SYS_RST_I,
  // apb slave
  input  wire logic                                PSEL_I,
  input  wire logic                                PENABLE_I,
  input  wire logic                                PWRITE_I,
  input  wire logic [hpfc_pkg::HPFC_ADDR_W-1:0]    PADDR_I,
  input  wire logic [31:0]                         PWDATA_I,
  input  wire logic [3:0]                          PSTRB_I,
  output logic      [31:0]                         PRDATA_O,
  output logic                                     PREADY_O,
  output logic                                     PSLVERR_O,
  // straps and loader
  input  wire hpfc_pkg::hpfc_strap_t               STRAP_I,
  input  wire hpfc_pkg::hpfc_strap_t               LOADER_STRAP_I,
  input  wire logic                                LOADER_WRITE_I,
  // link state from the port logic
  input  wire hpfc_pkg::hpfc_link_t                LINK_I,
  // fifo levels
  input  wire logic                                HOST_RX_FIFO_LEVEL_I,
  input  wire logic                                SWITCH_RX_FIFO_LEVEL_I,
  // port controls
  output logic                                     SWITCH_TX_FIFO_PAUSE_O,
  output logic                                     HOST_TX_FIFO_PAUSE_O,
  output logic                                     BACKPRESSURE_EN_O,
  output logic                                     RX_PAUSE_EN_O,
  output logic                                     TX_PAUSE_EN_O
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // straps, loader and link come from outside the clock domain
  localparam int SYNC_W = 3 + 3 + 1 + 4 + 2;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_meta_reg;
  logic [SYNC_W-1:0] sync_out_reg;

  assign sync_raw = {STRAP_I, LOADER_STRAP_I, LOADER_WRITE_I, LINK_I,
                     HOST_RX_FIFO_LEVEL_I, SWITCH_RX_FIFO_LEVEL_I};

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      sync_meta_reg <= '0;
      sync_out_reg  <= '0;
    end else begin
      sync_meta_reg <= sync_raw;
      sync_out_reg  <= sync_meta_reg;
    end
  end

  hpfc_pkg::hpfc_strap_t strap_s;
  hpfc_pkg::hpfc_strap_t loader_s;
  logic                  loader_wr_s;
  hpfc_pkg::hpfc_link_t  link_s;
  logic                  host_rx_lvl_s;
  logic                  sw_rx_lvl_s;

  assign {strap_s, loader_s, loader_wr_s, link_s, host_rx_lvl_s, sw_rx_lvl_s} = sync_out_reg;

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // the strap is caught a few cycles after release, once the synchroniser
  // has filled; reset itself only loads constants
  localparam logic [1:0] STRAP_WAIT = hpfc_pkg::HPFC_STRAP_WAIT;

  logic [1:0] strap_wait_reg;
  logic       strap_take;
  logic       loader_wr_d_reg;
  logic       loader_take;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      strap_wait_reg <= '0;
    end else if (strap_wait_reg != STRAP_WAIT + 2'h1) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
    end
  end

  assign strap_take = (strap_wait_reg == STRAP_WAIT);

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      loader_wr_d_reg <= 1'b0;
    end else begin
      loader_wr_d_reg <= loader_wr_s;
    end
  end

  // a rising edge of the synchronised loader strobe reloads the defaults
  assign loader_take = loader_wr_s && !loader_wr_d_reg;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic addr_hit;
  logic wr_access;
  logic wr_lane0;

  assign addr_hit  = (PADDR_I[hpfc_pkg::HPFC_ADDR_W-1:2] ==
                      hpfc_pkg::HPFC_PAUSE_CTRL_OFFSET[hpfc_pkg::HPFC_ADDR_W-1:2]);
  assign wr_access = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && addr_hit;
  // every writable bit sits in byte lane 0
  assign wr_lane0  = wr_access && PSTRB_I[0];

  // ---------------------------------------------------------------
  // writable fields
  // ---------------------------------------------------------------
  logic hardwired_fifo_pause_link_reg;
  logic host_port_backpressure_on_reg;
  logic host_port_rx_pause_on_reg;
  logic host_port_tx_pause_on_reg;
  logic host_port_pause_override_reg;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      hardwired_fifo_pause_link_reg <= hpfc_pkg::HPFC_HWIRED_RESET;
    end else if (wr_lane0) begin
      hardwired_fifo_pause_link_reg <= PWDATA_I[hpfc_pkg::HPFC_HWIRED_BIT];
    end
  end

  // loader and strap loads win over a software write in the same cycle,
  // since they define the defaults the software expects to overwrite later
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      host_port_backpressure_on_reg <= 1'b0;
      host_port_rx_pause_on_reg     <= 1'b0;
      host_port_tx_pause_on_reg     <= 1'b0;
      host_port_pause_override_reg  <= 1'b0;
    end else if (strap_take) begin
      host_port_backpressure_on_reg <= strap_s.backpressure;
      host_port_rx_pause_on_reg     <= strap_s.full_duplex_pause;
      host_port_tx_pause_on_reg     <= strap_s.full_duplex_pause;
      host_port_pause_override_reg  <= strap_s.pause_override;
    end else if (loader_take) begin
      host_port_backpressure_on_reg <= loader_s.backpressure;
      host_port_rx_pause_on_reg     <= loader_s.full_duplex_pause;
      host_port_tx_pause_on_reg     <= loader_s.full_duplex_pause;
      host_port_pause_override_reg  <= loader_s.pause_override;
    end else if (wr_lane0) begin
      host_port_backpressure_on_reg <= PWDATA_I[hpfc_pkg::HPFC_BP_BIT];
      host_port_rx_pause_on_reg     <= PWDATA_I[hpfc_pkg::HPFC_RX_ON_BIT];
      host_port_tx_pause_on_reg     <= PWDATA_I[hpfc_pkg::HPFC_TX_ON_BIT];
      host_port_pause_override_reg  <= PWDATA_I[hpfc_pkg::HPFC_OVERRIDE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // effective settings
  // ---------------------------------------------------------------
  // the advertisement register lives elsewhere and has no write path here
  hpfc_pkg::hpfc_status_t status_now;

  hpfc_resolve u_resolve (
    .override_i (host_port_pause_override_reg),
    .rx_on_i    (host_port_rx_pause_on_reg),
    .tx_on_i    (host_port_tx_pause_on_reg),
    .link_i     (link_s),
    .status_o   (status_now)
  );

  // status is registered; before the straps are taken it is derived from the
  // reset field values and the link, afterwards it follows the strap load, software and loader writes and link
  hpfc_pkg::hpfc_status_t status_reg;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_now;
    end
  end

  // ---------------------------------------------------------------
  // port controls
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      SWITCH_TX_FIFO_PAUSE_O <= 1'b0;
      HOST_TX_FIFO_PAUSE_O   <= 1'b0;
    end else begin
      SWITCH_TX_FIFO_PAUSE_O <= hardwired_fifo_pause_link_reg && host_rx_lvl_s;
      HOST_TX_FIFO_PAUSE_O   <= hardwired_fifo_pause_link_reg && sw_rx_lvl_s;
    end
  end

  // the controls assume software obeyed the hard-wired setup order
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      BACKPRESSURE_EN_O <= 1'b0;
      RX_PAUSE_EN_O     <= 1'b0;
      TX_PAUSE_EN_O     <= 1'b0;
    end else begin
      BACKPRESSURE_EN_O <= host_port_backpressure_on_reg && link_s.half_duplex;
      RX_PAUSE_EN_O     <= status_now.rx_pause;
      TX_PAUSE_EN_O     <= status_now.tx_pause;
    end
  end

  // ---------------------------------------------------------------
  // apb response
  // ---------------------------------------------------------------
  // no wait state: ready rises in the first access cycle
  logic [31:0] read_word;

  always_comb begin
    read_word = hpfc_pkg::HPFC_ZERO_WORD;
    read_word[hpfc_pkg::HPFC_HWIRED_BIT]   = hardwired_fifo_pause_link_reg;
    read_word[hpfc_pkg::HPFC_BP_BIT]       = host_port_backpressure_on_reg;
    read_word[hpfc_pkg::HPFC_DUPLEX_BIT]   = status_reg.half_duplex;
    read_word[hpfc_pkg::HPFC_RX_ACT_BIT]   = status_reg.rx_pause;
    read_word[hpfc_pkg::HPFC_TX_ACT_BIT]   = status_reg.tx_pause;
    read_word[hpfc_pkg::HPFC_RX_ON_BIT]    = host_port_rx_pause_on_reg;
    read_word[hpfc_pkg::HPFC_TX_ON_BIT]    = host_port_tx_pause_on_reg;
    read_word[hpfc_pkg::HPFC_OVERRIDE_BIT] = host_port_pause_override_reg;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= hpfc_pkg::HPFC_ZERO_WORD;
    end else if (PSEL_I && !PENABLE_I) begin
      PREADY_O  <= 1'b1;
      PSLVERR_O <= !addr_hit;
      PRDATA_O  <= (!PWRITE_I && addr_hit) ? read_word : hpfc_pkg::HPFC_ZERO_WORD;
    end else begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= hpfc_pkg::HPFC_ZERO_WORD;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_hwired_link : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !hardwired_fifo_pause_link_reg |=> !SWITCH_TX_FIFO_PAUSE_O && !HOST_TX_FIFO_PAUSE_O)
    else $error("fifo pause driven while hard-wired mode off");

  chk_bp_gate : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    BACKPRESSURE_EN_O |-> $past(host_port_backpressure_on_reg))
    else $error("backpressure without enable");

  chk_duplex_read : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $rose(link_s.half_duplex) |=> ##1 status_reg.half_duplex)
    else $error("duplex status did not follow link");

  chk_rx_half_off : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    link_s.half_duplex |=> !RX_PAUSE_EN_O && !TX_PAUSE_EN_O)
    else $error("pause active in half duplex");

  chk_manual_rx : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (!link_s.half_duplex && !link_s.vphy_an_enable)
      |=> RX_PAUSE_EN_O == $past(host_port_rx_pause_on_reg))
    else $error("manual rx pause not applied");

  chk_manual_tx : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (!link_s.half_duplex && host_port_pause_override_reg)
      |=> TX_PAUSE_EN_O == $past(host_port_tx_pause_on_reg))
    else $error("override tx pause not applied");

  chk_an_select : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (!link_s.half_duplex && link_s.vphy_an_enable && !host_port_pause_override_reg)
      |=> RX_PAUSE_EN_O == $past(link_s.an_rx_pause))
    else $error("negotiated pause not applied");

  chk_strap_load : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    loader_take && !strap_take |=> host_port_pause_override_reg == $past(loader_s.pause_override))
    else $error("loader strap not taken");

  chk_reserved_zero : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    PREADY_O |-> PRDATA_O[31:8] == 24'h000000)
    else $error("reserved bits read nonzero");

  chk_hwired_on : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    hardwired_fifo_pause_link_reg
      |=> SWITCH_TX_FIFO_PAUSE_O == $past(host_rx_lvl_s)
          && HOST_TX_FIFO_PAUSE_O == $past(sw_rx_lvl_s))
    else $error("fifo levels not linked in hard-wired mode");

  chk_bp_duplex : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    host_port_backpressure_on_reg && link_s.half_duplex |=> BACKPRESSURE_EN_O)
    else $error("backpressure missing in half duplex");

  chk_status_rx : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (!link_s.half_duplex && host_port_pause_override_reg)
      |=> status_reg.rx_pause == $past(host_port_rx_pause_on_reg))
    else $error("rx pause status wrong under override");

  chk_status_tx : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (!link_s.half_duplex && link_s.vphy_an_enable && !host_port_pause_override_reg)
      |=> status_reg.tx_pause == $past(link_s.an_tx_pause))
    else $error("tx pause status wrong under negotiation");

  chk_an_off_tx : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (!link_s.half_duplex && !link_s.vphy_an_enable)
      |=> TX_PAUSE_EN_O == $past(host_port_tx_pause_on_reg))
    else $error("manual tx pause not applied");

  chk_strap_take : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    strap_take
      |=> host_port_backpressure_on_reg == $past(strap_s.backpressure)
          && host_port_tx_pause_on_reg == $past(strap_s.full_duplex_pause))
    else $error("reset strap not taken");

  chk_lane_strobe : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr_access && !PSTRB_I[0] && !strap_take && !loader_take
      |=> $stable(hardwired_fifo_pause_link_reg) && $stable(host_port_backpressure_on_reg))
    else $error("write without lane 0 strobe changed a field");

  chk_unmapped_err : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    PSEL_I && !PENABLE_I && !addr_hit |=> PSLVERR_O && PRDATA_O == hpfc_pkg::HPFC_ZERO_WORD)
    else $error("unmapped access not refused");

  chk_half_status : assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    link_s.half_duplex |=> status_reg.half_duplex && !status_reg.rx_pause && !status_reg.tx_pause)
    else $error("half duplex status wrong");

endmodule // hpfc_top

/* logic/hpfc_pkg.sv */
// package for the host port pause control register block
// assumes a 32-bit apb slave on the system clock
package hpfc_pkg;

  // register map
  localparam logic [11:0] HPFC_PAUSE_CTRL_OFFSET = 12'h1a8;
  localparam int          HPFC_ADDR_W            = 12;

  // field positions
  localparam int HPFC_OVERRIDE_BIT = 0;
  localparam int HPFC_TX_ON_BIT    = 1;
  localparam int HPFC_RX_ON_BIT    = 2;
  localparam int HPFC_TX_ACT_BIT   = 3;
  localparam int HPFC_RX_ACT_BIT   = 4;
  localparam int HPFC_DUPLEX_BIT   = 5;
  localparam int HPFC_BP_BIT       = 6;
  localparam int HPFC_HWIRED_BIT   = 7;

  // values after reset
  localparam logic       HPFC_HWIRED_RESET = 1'b0;

  // cycles after reset release before the straps are taken
  localparam logic [1:0] HPFC_STRAP_WAIT   = 2'h2;
  localparam logic [31:0] HPFC_ZERO_WORD   = 32'h0000_0000;

  // strap bundle, as latched at reset or rewritten by the loader
  typedef struct packed {
    logic backpressure;
    logic full_duplex_pause;
    logic pause_override;
  } hpfc_strap_t;

  // live link state reported by the port logic
  typedef struct packed {
    logic half_duplex;
    logic vphy_an_enable;
    logic an_rx_pause;
    logic an_tx_pause;
  } hpfc_link_t;

  // effective pause settings
  typedef struct packed {
    logic half_duplex;
    logic rx_pause;
    logic tx_pause;
  } hpfc_status_t;

endpackage

/* logic/hpfc_resolve.sv */
// effective pause resolution for the host-facing switch port
// assumes all inputs are already on the system clock
`timescale 1ns/1ps

module hpfc_resolve (
  // settings
  input  wire logic                  override_i,
  input  wire logic                  rx_on_i,
  input  wire logic                  tx_on_i,
  // link
  input  wire hpfc_pkg::hpfc_link_t  link_i,
  // result
  output hpfc_pkg::hpfc_status_t     status_o
);

  logic use_manual;

  // manual bits rule when override is set or negotiation is off
  assign use_manual = override_i || !link_i.vphy_an_enable;

  always_comb begin
    status_o.half_duplex = link_i.half_duplex;
    if (link_i.half_duplex) begin
      // pause frames only exist in full duplex
      status_o.rx_pause = 1'b0;
      status_o.tx_pause = 1'b0;
    end else if (use_manual) begin
      status_o.rx_pause = rx_on_i;
      status_o.tx_pause = tx_on_i;
    end else begin
      status_o.rx_pause = link_i.an_rx_pause;
      status_o.tx_pause = link_i.an_tx_pause;
    end
  end

endmodule // hpfc_resolve

/* verification/hpfc_port_model.sv */
// behavioural model of the host-facing port logic beside the pause block
// assumes the bench names the wanted link state and fifo levels
`timescale 1ns/1ps

module hpfc_port_model (
  // clock
  input  wire logic                 clk_i,
  // wanted state from the bench
  input  wire hpfc_pkg::hpfc_link_t link_cmd_i,
  input  wire logic                 host_lvl_cmd_i,
  input  wire logic                 sw_lvl_cmd_i,
  // port state as the block sees it
  output hpfc_pkg::hpfc_link_t      link_o,
  output logic                      host_rx_level_o,
  output logic                      switch_rx_level_o
);
  // ------------------------------------------------------------
  // port state
  // ------------------------------------------------------------
  // state moves only at clock edges, as a real port state machine would
  always_ff @(posedge clk_i) begin
    link_o            <= link_cmd_i;
    host_rx_level_o   <= host_lvl_cmd_i;
    switch_rx_level_o <= sw_lvl_cmd_i;
  end
endmodule // hpfc_port_model

/* verification/tb_top.sv */
// self-checking bench for the host port pause control block
// assumes the design package, design files and port model compile first
`timescale 1ns/1ps

module tb_top;
  localparam logic [11:0] REG = hpfc_pkg::HPFC_PAUSE_CTRL_OFFSET;
  logic                 sys_clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 psel    = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite  = 1'b0;
  logic [11:0]          paddr   = 12'h000;
  logic [31:0]          pwdata  = 32'h0000_0000;
  logic [3:0]           pstrb   = 4'h0;
  logic [31:0]          prdata;
  logic                 pready, pslverr;
  hpfc_pkg::hpfc_strap_t strap, ldr_strap;
  logic                 ldr_wr  = 1'b0;
  hpfc_pkg::hpfc_link_t link_cmd, link;
  logic                 host_cmd = 1'b0;
  logic                 sw_cmd   = 1'b0;
  logic                 host_lvl, sw_lvl, sw_pause, host_pause, bp_en, rx_en, tx_en;
  logic                 ovr, txo, rxo, bp, hw, err;
  logic [31:0]          rd, w, e;
  int                   seed = 83;
  int                   failures = 0;
  int                   comparisons = 0;
  int                   cycles = 0;

  always #2 sys_clk = ~sys_clk;

  hpfc_port_model model (.clk_i(sys_clk), .link_cmd_i(link_cmd), .host_lvl_cmd_i(host_cmd),
    .sw_lvl_cmd_i(sw_cmd), .link_o(link), .host_rx_level_o(host_lvl),
    .switch_rx_level_o(sw_lvl));

  hpfc_top DUT (.SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .STRAP_I(strap),
    .LOADER_STRAP_I(ldr_strap), .LOADER_WRITE_I(ldr_wr), .LINK_I(link),
    .HOST_RX_FIFO_LEVEL_I(host_lvl), .SWITCH_RX_FIFO_LEVEL_I(sw_lvl),
    .SWITCH_TX_FIFO_PAUSE_O(sw_pause), .HOST_TX_FIFO_PAUSE_O(host_pause),
    .BACKPRESSURE_EN_O(bp_en), .RX_PAUSE_EN_O(rx_en), .TX_PAUSE_EN_O(tx_en));

  // ------------------------------------------------------------
  // expectations and compares
  // ------------------------------------------------------------
  function automatic logic [31:0] exp_word();
    logic       man;
    logic [1:0] eff;
    man = ovr | ~link.vphy_an_enable;
    eff = man ? {rxo, txo} : {link.an_rx_pause, link.an_tx_pause};
    if (link.half_duplex) begin
      eff = 2'b00;
    end
    return {24'h00_0000, hw, bp, link.half_duplex, eff, rxo, txo, ovr};
  endfunction

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // ------------------------------------------------------------
  // apb master and checks
  // ------------------------------------------------------------
  // waits for pready with no fixed latency; the cycle limit ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // settle time covers the input synchronisers and the status register
  task automatic check_all();
    repeat (8) @(posedge sys_clk);
    apb(1'b0, REG, 32'h0000_0000, 4'hf);
    e = exp_word();
    cmp_word("control word", e, rd);
    cmp_bit("slave error", 1'b0, err);
    cmp_bit("rx pause enable", e[4], rx_en);
    cmp_bit("tx pause enable", e[3], tx_en);
    cmp_bit("backpressure", bp & link.half_duplex, bp_en);
    cmp_bit("switch tx pause", hw & host_lvl, sw_pause);
    cmp_bit("host tx pause", hw & sw_lvl, host_pause);
  endtask

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    strap = hpfc_pkg::hpfc_strap_t'($random(seed));
    ldr_strap = strap;
    link_cmd = hpfc_pkg::hpfc_link_t'(4'h0);
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    {bp, rxo, ovr} = strap;
    txo = rxo;
    hw = 1'b0;
    check_all();
    apb(1'b1, 12'h1ac, 32'hffff_ffff, 4'hf);
    apb(1'b0, 12'h1ac, 32'h0000_0000, 4'hf);
    cmp_word("unmapped data", 32'h0000_0000, rd);
    cmp_bit("unmapped error", 1'b1, err);
    apb(1'b1, REG, ~{24'h00_0000, hw, bp, 3'h0, rxo, txo, ovr}, 4'he);
    check_all();
    // all 16 link states first, then random ones; random words hit reserved bits
    for (int i = 0; i < 40; i++) begin
      w = $random(seed);
      link_cmd <= (i < 16) ? hpfc_pkg::hpfc_link_t'(i[3:0])
                           : hpfc_pkg::hpfc_link_t'(4'($random(seed)));
      host_cmd <= w[8];
      sw_cmd   <= w[9];
      apb(1'b1, REG, w, 4'hf);
      {hw, bp} = w[7:6];
      {rxo, txo, ovr} = w[2:0];
      check_all();
    end
    // software quiets the other methods in the same write that sets the fifo link
    apb(1'b1, REG, 32'h0000_0081, 4'hf);
    {hw, bp, rxo, txo, ovr} = 5'h11;
    for (int j = 0; j < 4; j++) begin
      host_cmd <= j[0];
      sw_cmd   <= j[1];
      check_all();
    end
    ldr_strap <= hpfc_pkg::hpfc_strap_t'(~strap);
    repeat (2) @(posedge sys_clk);
    ldr_wr <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ldr_wr <= 1'b0;
    {bp, rxo, ovr} = ~strap;
    txo = rxo;
    check_all();
    // a second reset latches fresh straps and drops the fifo link again
    w = $random(seed);
    strap   <= hpfc_pkg::hpfc_strap_t'(w[2:0]);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    {bp, rxo, ovr} = w[2:0];
    txo = rxo;
    hw = 1'b0;
    check_all();
    summarize();
  end
endmodule // tb_top
